/* File: core/nmc_pkg.sv */
package nmc_pkg;
	// Datapath widths
	localparam int PC_W = 10;
	localparam int PTR_W = 6;
	localparam int NIB_W = 4;
	localparam int LATCH_W = 8;
	localparam int STACK_DEPTH = 3;
	localparam int RAM_WORDS = 64;
	localparam int PAGE_OFS_W = 6;
	// Instruction cycle: oscillator periods and phase marks
	localparam int CYCLE_PERIODS = 16;
	localparam logic [3:0] PHASE_LAST = 4'(CYCLE_PERIODS - 1);
	localparam logic [3:0] PHASE_SAMPLE = 4'h7;
	localparam logic [3:0] SYNC_LAST = 4'h7;
	// Fixed addresses
	localparam logic [9:0] IRQ_VECTOR = 10'h0ff;
	localparam logic [3:0] CALL_PAGE = 4'h2;
	localparam logic [9:0] PC_RST = 10'h000;
	// Feature-select field positions and reset values
	localparam int FS_COUNTER = 0;
	localparam int FS_IRQ_ARM = 1;
	localparam int FS_PORT_DRIVE = 2;
	localparam int FS_SO_GATE = 3;
	localparam logic [3:0] FEATURE_RST = 4'h0;
	localparam logic SKL_RST = 1'b1;
	// Sampled pin slots
	localparam int PIN_SI = 0;
	localparam int PIN_IRQ = 1;
	localparam int PIN_CS = 2;
	localparam int PIN_WR = 3;
	localparam int PIN_RST = 4;
	localparam int NUM_PINS = 5;

	typedef enum {
		idle_op, add_carry_skip_op, swap_mem_op, load_ram_ptr_op,
		acc_to_digit_op, acc_to_row_op, digit_to_out_op, page_jump_op,
		page_call_op, long_jump_op, indirect_jump_op, rom_table_load_op,
		stack_pop_op, direct_ram_load_op, direct_ram_swap_op,
		swap_acc_shift_op, load_feature_op, acc_to_latch_op,
		latch_to_acc_op, port_to_acc_op, acc_to_gport_op
	} nmc_op_e;
endpackage

/* File: core/nmc_edge_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface nmc_edge_if;
	logic cyc;
	logic pin;
	logic now;
	logic level;
	logic fall;
	logic low_twice;
	modport core (output cyc, output pin, input now, input level,
		input fall, input low_twice);
	modport det (input cyc, input pin, output now, output level,
		output fall, output low_twice);
endinterface
`default_nettype wire

/* File: core/nmc_pin_sampler.sv */
`timescale 1ns/1ps
`default_nettype none
module nmc_pin_sampler (
	input wire logic mclk,
	input wire logic reset,
	nmc_edge_if.det e
);
	logic sync1;
	logic sync2;
	logic [2:0] hist;
	logic [2:0] next_hist;

	// One sample per instruction cycle; pins idle high
	always_comb begin
		next_hist = hist;
		if (e.cyc) begin
			next_hist = {hist[1:0], sync2};
		end
	end

	// Two-stage synchroniser, then the cycle-rate history
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			hist <= 3'b111;
		end else begin
			sync1 <= e.pin;
			sync2 <= sync1;
			hist <= next_hist;
		end
	end

	// A fall needs two low samples after a high, so short glitches die
	assign e.now = sync2;
	assign e.level = hist[0];
	assign e.fall = (hist == 3'b100);
	assign e.low_twice = (hist[1:0] == 2'b00);
endmodule
`default_nettype wire

/* File: core/nmc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module nmc_core #(
	parameter bit HOST_BUS = 1'b0
) (
	input wire logic mclk,
	input wire logic reset,
	input var nmc_pkg::nmc_op_e op,
	input wire logic [9:0] operand,
	input wire logic [7:0] rom_data,
	input wire logic serial_in,
	input wire logic gp_port_bit_one,
	input wire logic gp_port_bit_two,
	input wire logic gp_port_bit_three,
	input wire logic reset_req_n,
	input wire logic [7:0] port_in,
	output logic [9:0] pc_out,
	output logic instr_strobe,
	output logic skip_flag,
	output logic [7:0] port_out,
	output logic port_oe_n,
	output logic [3:0] gp_out_d,
	output logic [3:0] g_out,
	output logic ready_flag_out,
	output logic serial_out,
	output logic shift_clock_pin
);
	if (HOST_BUS !== 1'b0 && HOST_BUS !== 1'b1) begin : g_chk
		$error("HOST_BUS must be 0 or 1");
	end

	////////////////////////////////////////////////////////////////////////
	// Cycle timing
	logic [3:0] phase;
	logic [3:0] next_phase;
	logic strobe;
	logic sample;
	logic sync_pulse;

	// Sixteen oscillator periods per instruction cycle
	always_comb begin
		next_phase = phase + 4'h1;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			phase <= 4'h0;
		end else begin
			phase <= next_phase;
		end
	end

	assign strobe = (phase == nmc_pkg::PHASE_LAST);
	assign sample = (phase == nmc_pkg::PHASE_SAMPLE);
	assign sync_pulse = (phase <= nmc_pkg::SYNC_LAST);

	////////////////////////////////////////////////////////////////////////
	// Pin samplers
	nmc_edge_if eif [nmc_pkg::NUM_PINS] ();
	logic [nmc_pkg::NUM_PINS-1:0] pins;

	assign pins = {reset_req_n, gp_port_bit_three, gp_port_bit_two,
		gp_port_bit_one, serial_in};

	// Sampled mid-cycle so the result is steady when the cycle ends
	for (genvar gi = 0; gi < nmc_pkg::NUM_PINS; gi++) begin : g_pin
		assign eif[gi].cyc = sample;
		assign eif[gi].pin = pins[gi];
		nmc_pin_sampler u_samp (
			.mclk(mclk),
			.reset(reset),
			.e(eif[gi])
		);
	end

	logic si_level;
	logic si_fall;
	logic irq_fall;
	logic init;
	logic cs_low;
	logic rd_low;
	logic wr_low;

	assign si_level = eif[nmc_pkg::PIN_SI].level;
	assign si_fall = eif[nmc_pkg::PIN_SI].fall;
	assign irq_fall = eif[nmc_pkg::PIN_IRQ].fall;
	assign init = eif[nmc_pkg::PIN_RST].low_twice;
	// Host strobes use the synchronised level, not the cycle-rate sample
	assign cs_low = HOST_BUS & ~eif[nmc_pkg::PIN_CS].now;
	assign rd_low = HOST_BUS & ~eif[nmc_pkg::PIN_IRQ].now;
	assign wr_low = HOST_BUS & ~eif[nmc_pkg::PIN_WR].now;

	////////////////////////////////////////////////////////////////////////
	// Port input synchroniser and host write edge
	logic [7:0] port_m;
	logic [7:0] port_s;
	logic wr_low_d;
	logic host_write;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			port_m <= 8'h00;
			port_s <= 8'h00;
			wr_low_d <= 1'b0;
		end else begin
			port_m <= port_in;
			port_s <= port_m;
			wr_low_d <= wr_low;
		end
	end

	// Capture at the end of the write strobe, when host data is settled
	assign host_write = wr_low_d & ~wr_low & cs_low;

	////////////////////////////////////////////////////////////////////////
	// Core state
	logic [9:0] pc, next_pc;
	logic [9:0] stk [nmc_pkg::STACK_DEPTH];
	logic [9:0] next_stk [nmc_pkg::STACK_DEPTH];
	logic [3:0] acc, next_acc;
	logic carry, next_carry;
	logic [5:0] ptr, next_ptr;
	logic [7:0] q, next_q;
	logic [3:0] dreg, next_d;
	logic [3:0] greg, next_g;
	logic [3:0] shift_counter_reg, next_sio;
	logic clock_gate_latch, next_skl;
	logic [3:0] feature_select, next_feat;
	logic skip, next_skip;
	logic saved_skip, next_saved;
	logic irq_pend, next_irq_pend;
	logic ready, next_ready;
	logic [3:0] ram [nmc_pkg::RAM_WORDS];
	logic ram_we;
	logic [5:0] ram_wa;
	logic [3:0] ram_wd;
	logic [5:0] ram_ra;
	logic [3:0] ram_rd;
	logic [4:0] sum;
	logic chain;
	logic ack;
	logic direct;

	assign direct = (op == nmc_pkg::direct_ram_load_op) ||
		(op == nmc_pkg::direct_ram_swap_op);
	assign ram_ra = direct ? operand[5:0] : ptr;
	assign ram_rd = ram[ram_ra];
	assign sum = {1'b0, acc} + {1'b0, ram_rd} + {4'h0, carry};
	// Jumps and pointer loads hold off the interrupt until the chain ends
	assign chain = ~skip && (op inside {nmc_pkg::page_jump_op,
		nmc_pkg::page_call_op, nmc_pkg::long_jump_op,
		nmc_pkg::indirect_jump_op, nmc_pkg::stack_pop_op,
		nmc_pkg::load_ram_ptr_op});
	assign ack = strobe & ~HOST_BUS & irq_pend &
		feature_select[nmc_pkg::FS_IRQ_ARM] & ~chain;

	// Execute one instruction at each cycle end
	always_comb begin
		next_pc = pc;
		next_stk = stk;
		next_acc = acc;
		next_carry = carry;
		next_ptr = ptr;
		next_q = q;
		next_d = dreg;
		next_g = greg;
		next_sio = shift_counter_reg;
		next_skl = clock_gate_latch;
		next_feat = feature_select;
		next_skip = skip;
		next_saved = saved_skip;
		next_irq_pend = irq_pend;
		next_ready = ready;
		ram_we = 1'b0;
		ram_wa = ram_ra;
		ram_wd = acc;
		if (strobe) begin
			next_pc = pc + 10'h001;
			next_skip = 1'b0;
			if (feature_select[nmc_pkg::FS_COUNTER]) begin
				if (si_fall) begin
					next_sio = shift_counter_reg - 4'h1;
				end
			end else begin
				next_sio = {shift_counter_reg[2:0], si_level};
			end
			if (!skip) begin
				unique case (op)
				nmc_pkg::idle_op: begin
				end
				nmc_pkg::add_carry_skip_op: begin
					next_acc = sum[3:0];
					next_carry = sum[4];
					next_skip = sum[4];
				end
				nmc_pkg::swap_mem_op, nmc_pkg::direct_ram_swap_op: begin
					next_acc = ram_rd;
					ram_we = 1'b1;
				end
				nmc_pkg::direct_ram_load_op: next_acc = ram_rd;
				nmc_pkg::load_ram_ptr_op: next_ptr = operand[5:0];
				nmc_pkg::acc_to_digit_op: next_ptr[3:0] = acc;
				nmc_pkg::acc_to_row_op: next_ptr[5:4] = acc[1:0];
				nmc_pkg::digit_to_out_op: next_d = ptr[3:0];
				nmc_pkg::page_jump_op: begin
					next_pc = {pc[9:6], operand[5:0]};
				end
				nmc_pkg::page_call_op: begin
					next_stk[2] = stk[1];
					next_stk[1] = stk[0];
					next_stk[0] = pc + 10'h001;
					next_pc = {nmc_pkg::CALL_PAGE, operand[5:0]};
				end
				nmc_pkg::long_jump_op: next_pc = operand;
				nmc_pkg::indirect_jump_op: next_pc = {pc[9:8], rom_data};
				nmc_pkg::rom_table_load_op: next_q = rom_data;
				nmc_pkg::stack_pop_op: begin
					next_pc = stk[0];
					next_stk[0] = stk[1];
					next_stk[1] = stk[2];
					next_skip = saved_skip;
					next_saved = 1'b0;
				end
				nmc_pkg::swap_acc_shift_op: begin
					next_acc = shift_counter_reg;
					next_sio = acc;
					next_skl = carry;
				end
				nmc_pkg::load_feature_op: next_feat = operand[3:0];
				nmc_pkg::acc_to_latch_op: next_q = {acc, ram_rd};
				nmc_pkg::latch_to_acc_op: begin
					next_acc = q[7:4];
					ram_wd = q[3:0];
					ram_we = 1'b1;
				end
				nmc_pkg::port_to_acc_op: next_acc = port_s[3:0];
				nmc_pkg::acc_to_gport_op: begin
					next_g = acc;
					next_ready = acc[0];
				end
			endcase
			end
			// Pending fall is sticky; a new fall beats the clear
			if (ack) begin
				next_stk[2] = next_stk[1];
				next_stk[1] = next_stk[0];
				next_stk[0] = next_pc;
				next_pc = nmc_pkg::IRQ_VECTOR;
				next_feat[nmc_pkg::FS_IRQ_ARM] = 1'b0;
				next_saved = next_skip;
				next_skip = 1'b0;
				next_irq_pend = 1'b0;
			end
			if (irq_fall && feature_select[nmc_pkg::FS_IRQ_ARM]) begin
				next_irq_pend = 1'b1;
			end
		end
		// The host write is the event, so it wins over a software set
		if (host_write) begin
			next_q = port_s;
			next_ready = 1'b0;
		end
		if (init) begin
			next_pc = nmc_pkg::PC_RST;
			next_acc = 4'h0;
			next_carry = 1'b0;
			next_ptr = 6'h00;
			next_d = 4'h0;
			next_g = 4'h0;
			next_feat = nmc_pkg::FEATURE_RST;
			next_skl = nmc_pkg::SKL_RST;
			next_skip = 1'b0;
			next_saved = 1'b0;
			next_irq_pend = 1'b0;
			next_ready = 1'b0;
			ram_we = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pc <= nmc_pkg::PC_RST;
			stk <= '{default: 10'h000};
			acc <= 4'h0;
			carry <= 1'b0;
			ptr <= 6'h00;
			q <= 8'h00;
			dreg <= 4'h0;
			greg <= 4'h0;
			shift_counter_reg <= 4'h0;
			clock_gate_latch <= nmc_pkg::SKL_RST;
			feature_select <= nmc_pkg::FEATURE_RST;
			skip <= 1'b0;
			saved_skip <= 1'b0;
			irq_pend <= 1'b0;
			ready <= 1'b0;
		end else begin
			pc <= next_pc;
			stk <= next_stk;
			acc <= next_acc;
			carry <= next_carry;
			ptr <= next_ptr;
			q <= next_q;
			dreg <= next_d;
			greg <= next_g;
			shift_counter_reg <= next_sio;
			clock_gate_latch <= next_skl;
			feature_select <= next_feat;
			skip <= next_skip;
			saved_skip <= next_saved;
			irq_pend <= next_irq_pend;
			ready <= next_ready;
		end
	end

	// RAM keeps its contents through reset, so it has no reset branch
	always_ff @(posedge mclk) begin
		if (ram_we) begin
			ram[ram_wa] <= ram_wd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered pin outputs
	logic next_oe_n;
	logic next_so;
	logic next_sk;

	always_comb begin
		if (HOST_BUS) begin
			next_oe_n = ~(cs_low & rd_low);
		end else begin
			next_oe_n = ~feature_select[nmc_pkg::FS_PORT_DRIVE];
		end
		if (feature_select[nmc_pkg::FS_COUNTER]) begin
			next_so = feature_select[nmc_pkg::FS_SO_GATE];
			next_sk = clock_gate_latch;
		end else begin
			next_so = feature_select[nmc_pkg::FS_SO_GATE] & shift_counter_reg[3];
			next_sk = clock_gate_latch & sync_pulse;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			port_oe_n <= 1'b1;
			serial_out <= 1'b0;
			shift_clock_pin <= 1'b0;
			instr_strobe <= 1'b0;
		end else begin
			port_oe_n <= next_oe_n;
			serial_out <= next_so;
			shift_clock_pin <= next_sk;
			instr_strobe <= strobe;
		end
	end

	assign pc_out = pc;
	assign skip_flag = skip;
	assign port_out = q;
	assign gp_out_d = dreg;
	assign g_out = greg;
	assign ready_flag_out = ready;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	a_pc_sequential: assert property (
		strobe && !init && !ack && (skip || op == nmc_pkg::idle_op)
		|=> pc == $past(pc) + 10'h001)
		else $error("pc did not step by one");
	a_irq_vector: assert property (
		ack && !init |=> pc == nmc_pkg::IRQ_VECTOR &&
		!feature_select[nmc_pkg::FS_IRQ_ARM] &&
		stk[1] == $past(stk[0]))
		else $error("interrupt entry wrong");
	a_sk_mode: assert property (
		$past(feature_select[nmc_pkg::FS_COUNTER]) |->
		shift_clock_pin == $past(clock_gate_latch))
		else $error("shift clock not latch in counter mode");
	a_so_counter: assert property (
		$past(feature_select[nmc_pkg::FS_COUNTER]) |->
		serial_out == $past(feature_select[nmc_pkg::FS_SO_GATE]))
		else $error("serial out not gate bit");
	a_so_gated: assert property (
		$past(feature_select == 4'h0) |-> !serial_out)
		else $error("serial out not held low");
	a_shift_left: assert property (
		strobe && !init && !feature_select[nmc_pkg::FS_COUNTER] &&
		(skip || op != nmc_pkg::swap_acc_shift_op)
		|=> shift_counter_reg == {$past(shift_counter_reg[2:0]), $past(si_level)})
		else $error("shifter did not shift");
	a_count_down: assert property (
		strobe && !init && si_fall && feature_select[nmc_pkg::FS_COUNTER]
		&& (skip || op != nmc_pkg::swap_acc_shift_op)
		|=> shift_counter_reg == $past(shift_counter_reg) - 4'h1)
		else $error("counter did not decrement");
	a_port_float: assert property (
		!HOST_BUS && $past(!feature_select[nmc_pkg::FS_PORT_DRIVE])
		|-> port_oe_n)
		else $error("port driven while disabled");
	a_skip_restore: assert property (
		strobe && !init && !skip && op == nmc_pkg::stack_pop_op
		|=> skip == $past(saved_skip) && pc == $past(stk[0]))
		else $error("pop did not restore skip");
	a_swap_latch: assert property (
		strobe && !init && !skip && op == nmc_pkg::swap_acc_shift_op
		|=> clock_gate_latch == $past(carry) && acc == $past(shift_counter_reg))
		else $error("swap did not copy carry");
	a_sync_shape: assert property (
		phase == 4'h0 |-> sync_pulse [*8] ##1 !sync_pulse [*8])
		else $error("sync pulse shape wrong");
endmodule
`default_nettype wire

/* File: sim/nmc_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module nmc_far_side (
	input wire logic [9:0] pc,
	input wire logic [7:0] port_out,
	input wire logic port_oe_n,
	output logic [7:0] rom_data,
	output logic [7:0] port_in
);
	////////////////////////////////////////////////////////////////////////
	// Program memory: bits rotated and XORed with 8'ha5 so neighbours differ
	assign rom_data = {pc[1:0], pc[7:2]} ^ 8'ha5;
	// Port pins float up through their load when the core lets go
	assign port_in = (port_oe_n === 1'b0) ? port_out : 8'hff;
endmodule
`default_nettype wire

/* File: sim/nibble_mcu_core_control_io_test.sv */
`timescale 1ns/1ps
`default_nettype none
module nibble_mcu_core_control_io_test;
	typedef struct {
		nmc_pkg::nmc_op_e op;
		logic [9:0] arg;
		logic [9:0] pc;
		logic [3:0] d;
	} nmc_row_s;
	logic mclk, reset, serial_in, irq_pin, reset_req_n;
	nmc_pkg::nmc_op_e op;
	logic [9:0] operand, pc_out;
	logic [7:0] rom_data, port_in, port_out;
	logic instr_strobe, skip_flag, port_oe_n, ready_flag_out;
	logic serial_out, shift_clock_pin;
	logic [3:0] gp_out_d, g_out;
	int fails = 0;
	int tests_run = 0;
	nmc_row_s rows[15] = '{
		'{nmc_pkg::idle_op, 10'h000, 10'h001, 4'h0},
		'{nmc_pkg::long_jump_op, 10'h3fe, 10'h3fe, 4'h0},
		'{nmc_pkg::idle_op, 10'h000, 10'h3ff, 4'h0},
		'{nmc_pkg::idle_op, 10'h000, 10'h000, 4'h0},
		'{nmc_pkg::page_jump_op, 10'h015, 10'h015, 4'h0},
		'{nmc_pkg::page_call_op, 10'h001, 10'h081, 4'h0},
		'{nmc_pkg::long_jump_op, 10'h100, 10'h100, 4'h0},
		'{nmc_pkg::page_call_op, 10'h003, 10'h083, 4'h0},
		'{nmc_pkg::page_call_op, 10'h004, 10'h084, 4'h0},
		'{nmc_pkg::page_call_op, 10'h005, 10'h085, 4'h0},
		'{nmc_pkg::stack_pop_op, 10'h000, 10'h085, 4'h0},
		'{nmc_pkg::stack_pop_op, 10'h000, 10'h084, 4'h0},
		'{nmc_pkg::stack_pop_op, 10'h000, 10'h101, 4'h0},
		'{nmc_pkg::load_ram_ptr_op, 10'h03a, 10'h102, 4'h0},
		'{nmc_pkg::digit_to_out_op, 10'h000, 10'h103, 4'ha}
	};

	////////////////////////////////////////////////////////////////////////
	// Core, with the CS and WR host-bus strobes held inactive since the option is off
	nmc_core dut (.mclk(mclk), .reset(reset), .op(op), .operand(operand),
		.rom_data(rom_data), .serial_in(serial_in),
		.gp_port_bit_one(irq_pin), .gp_port_bit_two(1'b1),
		.gp_port_bit_three(1'b1), .reset_req_n(reset_req_n),
		.port_in(port_in), .pc_out(pc_out), .instr_strobe(instr_strobe),
		.skip_flag(skip_flag), .port_out(port_out), .port_oe_n(port_oe_n),
		.gp_out_d(gp_out_d), .g_out(g_out),
		.ready_flag_out(ready_flag_out), .serial_out(serial_out),
		.shift_clock_pin(shift_clock_pin));
	nmc_far_side far (.pc(pc_out), .port_out(port_out),
		.port_oe_n(port_oe_n), .rom_data(rom_data), .port_in(port_in));

	// Oscillator, 40 ns period
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Present one op at a falling edge, return once its late outputs settle
	task automatic step(input nmc_pkg::nmc_op_e o, input logic [9:0] a);
		int n;
		n = 0;
		op = o;
		operand = a;
		@(negedge mclk);
		while (instr_strobe !== 1'b1 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 40) begin
			fails++;
			results();
		end
		@(negedge mclk);
	endtask

	task automatic idles(input int k);
		repeat (k) step(nmc_pkg::idle_op, 10'h000);
	endtask

	// Hang guard: the whole sequence needs well under a millisecond
	initial begin
		#2000000;
		fails++;
		results();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [9:0] p;
		logic [7:0] l;
		logic [4:0] s;
		int n;
		reset = 1'b1;
		op = nmc_pkg::idle_op;
		operand = 10'h000;
		serial_in = 1'b1;
		irq_pin = 1'b1;
		reset_req_n = 1'b1;
		repeat (16) @(negedge mclk);
		reset = 1'b0;
		check("pc", pc_out, 10'h000);
		check("oe_n", port_oe_n, 1'b1);
		check("so", serial_out, 1'b0);
		check("latch", port_out, 8'h00);
		$display("reset test done");
		// Sequencing, paging, stack depth and digit output
		foreach (rows[i]) begin
			step(rows[i].op, rows[i].arg);
			check("pc", pc_out, rows[i].pc);
			check("d", gp_out_d, rows[i].d);
		end
		$display("table test done");
		// Counter mode pins, then shift mode with serial in held
		step(nmc_pkg::load_feature_op, 10'h009);
		check("so", serial_out, 1'b1);
		check("sk", shift_clock_pin, 1'b1);
		step(nmc_pkg::load_feature_op, 10'h001);
		check("so", serial_out, 1'b0);
		step(nmc_pkg::load_feature_op, 10'h008);
		idles(6);
		check("so", serial_out, 1'b1);
		serial_in = 1'b0;
		idles(6);
		check("so", serial_out, 1'b0);
		serial_in = 1'b1;
		step(nmc_pkg::load_feature_op, 10'h000);
		idles(6);
		check("so", serial_out, 1'b0);
		n = 0;
		repeat (16) begin
			@(negedge mclk);
			n += (shift_clock_pin === 1'b1) ? 1 : 0;
		end
		check("sk_high", 16'(n), 16'd8);
		// Shifter now 4'hf; one wide fall in counter mode leaves 4'he
		step(nmc_pkg::load_feature_op, 10'h001);
		serial_in = 1'b0;
		idles(3);
		serial_in = 1'b1;
		idles(3);
		step(nmc_pkg::swap_acc_shift_op, 10'h000);
		check("sk", shift_clock_pin, 1'b0);
		step(nmc_pkg::acc_to_latch_op, 10'h000);
		check("latch_hi", port_out[7:4], 4'he);
		$display("serial test done");
		// Port drivers and a table load from program memory
		step(nmc_pkg::load_feature_op, 10'h004);
		check("oe_n", port_oe_n, 1'b0);
		p = pc_out;
		l = {p[1:0], p[7:2]} ^ 8'ha5;
		step(nmc_pkg::rom_table_load_op, 10'h000);
		check("latch", port_out, l);
		check("pins", port_in, port_out);
		step(nmc_pkg::load_feature_op, 10'h000);
		check("oe_n", port_oe_n, 1'b1);
		$display("port test done");
		// Latch halves into acc and RAM, add them, skip on carry
		step(nmc_pkg::latch_to_acc_op, 10'h000);
		step(nmc_pkg::acc_to_gport_op, 10'h000);
		check("g", g_out, l[7:4]);
		check("ready", ready_flag_out, l[4]);
		s = {1'b0, l[7:4]} + {1'b0, l[3:0]};
		step(nmc_pkg::add_carry_skip_op, 10'h000);
		check("skip", skip_flag, s[4]);
		step(nmc_pkg::acc_to_gport_op, 10'h000);
		check("g_sum", g_out, s[4] ? l[7:4] : s[3:0]);
		check("noskip", skip_flag, 1'b0);
		$display("adder test done");
		// Armed interrupt, return, then a second pulse that is ignored
		step(nmc_pkg::load_feature_op, 10'h002);
		irq_pin = 1'b0;
		n = 0;
		p = pc_out;
		while (pc_out !== nmc_pkg::IRQ_VECTOR && n < 8) begin
			p = pc_out;
			step(nmc_pkg::idle_op, 10'h000);
			n++;
		end
		irq_pin = 1'b1;
		check("vector", pc_out, 10'h0ff);
		step(nmc_pkg::stack_pop_op, 10'h000);
		check("return", pc_out, p + 10'h001);
		p = pc_out;
		irq_pin = 1'b0;
		idles(3);
		irq_pin = 1'b1;
		idles(3);
		check("disarmed", pc_out, p + 10'h006);
		$display("interrupt test done");
		// A one-cycle reset request is too short; a long one clears
		p = pc_out;
		reset_req_n = 1'b0;
		step(nmc_pkg::idle_op, 10'h000);
		reset_req_n = 1'b1;
		idles(3);
		check("short_req", pc_out, p + 10'h004);
		step(nmc_pkg::load_feature_op, 10'h00d);
		reset_req_n = 1'b0;
		idles(5);
		check("pc", pc_out, 10'h000);
		check("oe_n", port_oe_n, 1'b1);
		check("so", serial_out, 1'b0);
		reset_req_n = 1'b1;
		$display("reset request test done");
		results();
	end
endmodule
`default_nettype wire
